//--- verilog/spms_pkg.sv
/*
  Shared constants and types of the eight-bit serial peripheral port:
  register byte offsets, field positions, reset values, engine states and
  the pin carriers. Assumes 32-bit Avalon-MM access, one register a word.
*/
package spms_pkg;

  // Register byte offsets, one aligned word each.
  localparam logic [4:0] ADDR_CTRL_ONE   = 5'h00;
  localparam logic [4:0] ADDR_CTRL_TWO   = 5'h04;
  localparam logic [4:0] ADDR_RATE       = 5'h08;
  localparam logic [4:0] ADDR_STATUS     = 5'h0C;
  localparam logic [4:0] ADDR_MATCH      = 5'h10;
  localparam logic [4:0] ADDR_DATA       = 5'h14;

  // First control register fields.
  localparam int C1_RX_FAULT_IE = 7;
  localparam int C1_ENABLE      = 6;
  localparam int C1_TX_IE       = 5;
  localparam int C1_MASTER      = 4;
  localparam int C1_POLARITY    = 3;
  localparam int C1_PHASE       = 2;
  localparam int C1_SELECT_OE   = 1;
  localparam int C1_LOW_FIRST   = 0;

  // Second control register fields; bit 6 is unimplemented.
  localparam int C2_MATCH_IE    = 7;
  localparam int C2_TX_DMA      = 5;
  localparam int C2_FAULT_EN    = 4;
  localparam int C2_SHARED_OE   = 3;
  localparam int C2_RX_DMA      = 2;
  localparam int C2_STOP_WAIT   = 1;
  localparam int C2_SINGLE_PIN  = 0;
  localparam logic [7:0] C2_WRITE_MASK = 8'hBF;

  // Rate divider fields; bit 7 is reserved.
  localparam int RATE_PRE_LSB   = 4;
  localparam logic [7:0] RATE_WRITE_MASK = 8'h7F;

  // Status register fields; bits 3 to 0 read as zero.
  localparam int ST_RX_FULL     = 7;
  localparam int ST_MATCH       = 6;
  localparam int ST_TX_EMPTY    = 5;
  localparam int ST_FAULT       = 4;

  // Reset values.
  localparam logic [7:0] CTRL_ONE_RESET = 8'h04;
  localparam logic [7:0] CTRL_TWO_RESET = 8'h00;
  localparam logic [7:0] RATE_RESET     = 8'h00;
  localparam logic [7:0] MATCH_RESET    = 8'h00;
  localparam logic [7:0] DATA_RESET     = 8'h00;

  // Sixteen clock edges carry one byte; the counter wraps to zero on the last one.
  localparam logic [3:0] LAST_EDGE      = 4'hF;

  typedef enum logic [1:0] {
    SPMS_IDLE   = 2'b00,
    SPMS_SHIFT  = 2'b01,
    SPMS_FINISH = 2'b10
  } spms_state_type;

  // Pin levels arriving from the pads.
  typedef struct packed {
    logic sclk_i;
    logic mosi_i;
    logic miso_i;
    logic ss_n_i;
  } spms_pin_in_type;

  // Pin levels and enables going to the pads.
  typedef struct packed {
    logic sclk_o;
    logic sclk_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } spms_pin_out_type;

endpackage : spms_pkg

//--- verilog/spms_port.sv
/*
  Eight-bit serial peripheral port, master or slave, with its register
  file on an Avalon-MM slave with waitrequest. Assumes one clock sys_clk,
  a synchronous active-high reset, and pads that resolve each pin from
  the level and enable given here.
*/
// The implementer's own choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps

// Operation
// - First control register holds enable, interrupt enables, role, clock and options.
// - Second control register holds match enable, fault enable, shared pin and extras.
// - Rate register sets prescaler and divisor that make the master serial clock.
// - Match register is compared with each byte copied to the receive buffer to raise a match.
// - Software reads status with transmit empty set, then writes data; master starts.
// - Control one bit 7 enables receive and fault interrupts, bit 6 enables port.
// - Control one bit 5 enables transmit interrupt, bit 4 selects master.
// - Bit 3 picks clock polarity; bit 2 puts first edge at bit start.
// - Bit 1 sets select pin use under fault detect; bit 0 low bit first.
// - Control two bit 7 enables match interrupt; bit 6 unimplemented.
// - Control two bit 4 fault detect, bit 5 transmit DMA, bit 2 receive DMA.
// - Bit 3 clear makes shared pin input; bit 0 clear uses separate pins.
// - Control two bit 1 set stops serial clocks while the processor waits.
// - Rate bits 6 to 4 pick prescale, 000 is one; bit 7 reserved.
// - Rate bits 3 to 0 pick divisor, 0000 divides by two.
// - Master serial clock is never faster than the bus clock over two.
// - Status bit 7 sets when the receive buffer fills.
// - Status bit 6 sets when the received byte equals the match value.
// - Status bit 5 sets when the transmit buffer can take a byte.
// - Status bit 4 is the mode fault flag; bits 3 to 0 reserved.
// - Match register holds an eight-bit value in bits 0 to 7.
// - Data register takes the byte to send and returns the byte received.
// - Interrupt rises while the port is enabled and any flag is set together with its enable.
// - Mode fault aborts the transfer and clears master select to slave.
// - With the port disabled the engine rests while registers stay reachable.
module spms_port (
  input  wire logic                       sys_clk,
  input  wire logic                       rst,
  input  wire logic [4:0]                 avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  output      logic [31:0]                avs_readdata,
  output      logic                       avs_waitrequest,
  input  wire logic                       cpu_wait,
  input  wire spms_pkg::spms_pin_in_type  pins_in,
  output      spms_pkg::spms_pin_out_type pins_out,
  output      logic                       irq,
  output      logic                       tx_dma_req,
  output      logic                       rx_dma_req
);

  logic [7:0]                  ctrl_one;
  logic [7:0]                  ctrl_two;
  logic [7:0]                  rate_div;
  logic [7:0]                  match_value;
  logic [7:0]                  tx_data;
  logic [7:0]                  rx_data;
  logic                        rx_full;
  logic                        match_flag;
  logic                        tx_empty;
  logic                        fault_flag;
  logic                        rx_armed;
  logic                        tx_armed;
  logic                        fault_armed;
  spms_pkg::spms_pin_in_type   pin_meta;
  spms_pkg::spms_pin_in_type   pin_sync;
  logic                        sclk_prev;
  spms_pkg::spms_state_type    state;
  logic [19:0]                 half_cnt;
  logic [19:0]                 half_len;
  logic [3:0]                  edge_cnt;
  logic                        sclk_q;
  logic [7:0]                  tx_sh;
  logic [7:0]                  rx_sh;
  logic [7:0]                  next_tx;
  logic [7:0]                  load_val;
  logic                        out_bit;
  logic [7:0]                  read_mux;

  // Bus handshake terms; a request completes on the edge with wait low.
  logic bus_req;
  logic rd_done;
  logic wr_done;
  logic [7:0] wdata;
  assign bus_req = avs_read | avs_write;
  assign rd_done = avs_read & ~avs_waitrequest;
  assign wr_done = avs_write & ~avs_waitrequest;
  assign wdata   = avs_writedata[7:0];

  logic wr_c1;
  logic wr_c2;
  logic wr_rate;
  logic wr_status;
  logic wr_match;
  logic wr_data;
  logic rd_status;
  logic rd_data;
  assign wr_c1     = wr_done & (avs_address == spms_pkg::ADDR_CTRL_ONE);
  assign wr_c2     = wr_done & (avs_address == spms_pkg::ADDR_CTRL_TWO);
  assign wr_rate   = wr_done & (avs_address == spms_pkg::ADDR_RATE);
  assign wr_status = wr_done & (avs_address == spms_pkg::ADDR_STATUS);
  assign wr_match  = wr_done & (avs_address == spms_pkg::ADDR_MATCH);
  assign wr_data   = wr_done & (avs_address == spms_pkg::ADDR_DATA);
  assign rd_status = rd_done & (avs_address == spms_pkg::ADDR_STATUS);
  assign rd_data   = rd_done & (avs_address == spms_pkg::ADDR_DATA);

  // Control field views.
  logic enabled;
  logic is_master;
  logic clock_phase;
  logic clock_polarity;
  logic low_first;
  logic single_pin;
  logic shared_oe;
  logic fault_en;
  logic select_oe;
  assign enabled    = ctrl_one[spms_pkg::C1_ENABLE];
  assign is_master  = ctrl_one[spms_pkg::C1_MASTER];
  assign clock_polarity       = ctrl_one[spms_pkg::C1_POLARITY];
  assign clock_phase       = ctrl_one[spms_pkg::C1_PHASE];
  assign select_oe  = ctrl_one[spms_pkg::C1_SELECT_OE];
  assign low_first  = ctrl_one[spms_pkg::C1_LOW_FIRST];
  assign fault_en   = ctrl_two[spms_pkg::C2_FAULT_EN];
  assign shared_oe  = ctrl_two[spms_pkg::C2_SHARED_OE];
  assign single_pin = ctrl_two[spms_pkg::C2_SINGLE_PIN];

  // Every read or write answers one cycle after it is first seen, so
  // the read mux is sampled while waitrequest is still high.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(bus_req & avs_waitrequest);
    end
  end

  // Read data; unmapped offsets and reserved bits read as zero.
  always_comb begin
    unique case (avs_address)
      spms_pkg::ADDR_CTRL_ONE: read_mux = ctrl_one;
      spms_pkg::ADDR_CTRL_TWO: read_mux = ctrl_two;
      spms_pkg::ADDR_RATE:     read_mux = rate_div;
      spms_pkg::ADDR_STATUS:   read_mux = {rx_full, match_flag, tx_empty,
                                           fault_flag, 4'h0};
      spms_pkg::ADDR_MATCH:    read_mux = match_value;
      spms_pkg::ADDR_DATA:     read_mux = rx_data;
      default:                 read_mux = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= {24'h00_0000, read_mux};
    end
  end

  // Mode fault: a master watching its select pin sees it pulled low.
  logic fault_event;
  assign fault_event = enabled & is_master & fault_en & ~select_oe &
                       ~pin_sync.ss_n_i;

  // First control register; a fault drops master select after any write.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_one <= spms_pkg::CTRL_ONE_RESET;
    end else begin
      if (wr_c1) begin
        ctrl_one <= wdata;
      end
      if (fault_event) begin
        ctrl_one[spms_pkg::C1_MASTER] <= 1'b0;
      end
    end
  end

  // Remaining software registers; unimplemented bits stay zero.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_two    <= spms_pkg::CTRL_TWO_RESET;
      rate_div    <= spms_pkg::RATE_RESET;
      match_value <= spms_pkg::MATCH_RESET;
      tx_data     <= spms_pkg::DATA_RESET;
    end else begin
      if (wr_c2) begin
        ctrl_two <= wdata & spms_pkg::C2_WRITE_MASK;
      end
      if (wr_rate) begin
        rate_div <= wdata & spms_pkg::RATE_WRITE_MASK;
      end
      if (wr_match) begin
        match_value <= wdata;
      end
      if (wr_data) begin
        tx_data <= wdata;
      end
    end
  end

  // Pads are foreign to sys_clk, so each passes two flops first.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_meta  <= '1;
      pin_sync  <= '1;
      sclk_prev <= 1'b1; // Matches the synced idle level, so no false edge.
    end else begin
      pin_meta  <= pins_in;
      pin_sync  <= pin_meta;
      sclk_prev <= pin_sync.sclk_i;
    end
  end

  // Half period is (prescale + 1) << rate, never below one cycle, which
  // keeps the serial clock at or under sys_clk over two.
  always_comb begin
    half_len = 20'(({17'h0_0000, rate_div[6:spms_pkg::RATE_PRE_LSB]} +
                     20'h0_0001) << rate_div[3:0]);
  end

  logic freeze;
  logic m_tick;
  logic s_edge;
  logic edge_now;
  logic sample_now;
  logic drive_now;
  logic serial_in;
  assign freeze   = cpu_wait & ctrl_two[spms_pkg::C2_STOP_WAIT];
  assign m_tick   = is_master & (state == spms_pkg::SPMS_SHIFT) & ~freeze &
                    (half_cnt == half_len - 20'h0_0001);
  assign s_edge   = ~is_master & (state == spms_pkg::SPMS_SHIFT) &
                    (pin_sync.sclk_i != sclk_prev);
  assign edge_now = m_tick | s_edge;
  // Even edges lead; phase picks which kind samples and which drives.
  assign sample_now = edge_now & (~edge_cnt[0] ^ clock_phase);
  assign drive_now  = edge_now & ~(~edge_cnt[0] ^ clock_phase) &
                      (edge_cnt != 4'h0);
  // The shared pin is the master's out pin and the slave's out pin.
  assign serial_in  = (is_master ^ single_pin) ? pin_sync.miso_i
                                               : pin_sync.mosi_i;

  // Half period counter runs only while a master shifts.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      half_cnt <= 20'h0_0000;
    end else if (~is_master | (state != spms_pkg::SPMS_SHIFT)) begin
      half_cnt <= 20'h0_0000;
    end else if (~freeze) begin
      if (m_tick) begin
        half_cnt <= 20'h0_0000;
      end else begin
        half_cnt <= half_cnt + 20'h0_0001;
      end
    end
  end

  // Start conditions, abort conditions and the completion copy.
  logic start_now;
  logic abort_now;
  logic consume;
  logic rx_clear;
  logic copy_now;
  assign start_now = (state == spms_pkg::SPMS_IDLE) & enabled & ~fault_flag &
                     (is_master ? ~tx_empty : ~pin_sync.ss_n_i);
  assign abort_now = ~enabled | fault_event |
                     (~is_master & pin_sync.ss_n_i);
  assign consume   = start_now & ~tx_empty;
  assign rx_clear  = rd_data & rx_armed;
  // A full buffer not yet serviced drops the new byte.
  assign copy_now  = (state == spms_pkg::SPMS_FINISH) & (~rx_full | rx_clear);

  // Transfer sequencer.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state <= spms_pkg::SPMS_IDLE;
    end else begin
      unique case (state)
        spms_pkg::SPMS_IDLE: begin
          if (start_now) begin
            state <= spms_pkg::SPMS_SHIFT;
          end
        end
        spms_pkg::SPMS_SHIFT: begin
          if (abort_now) begin
            state <= spms_pkg::SPMS_IDLE;
          end else if (edge_now & (edge_cnt == spms_pkg::LAST_EDGE)) begin
            state <= spms_pkg::SPMS_FINISH;
          end
        end
        spms_pkg::SPMS_FINISH: begin
          state <= spms_pkg::SPMS_IDLE;
        end
        default: begin
          state <= spms_pkg::SPMS_IDLE;
        end
      endcase
    end
  end

  // Edge counter and the master's own serial clock.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      edge_cnt <= 4'h0;
      sclk_q   <= 1'b0;
    end else if (state != spms_pkg::SPMS_SHIFT) begin
      edge_cnt <= 4'h0;
      sclk_q   <= clock_polarity;
    end else if (edge_now) begin
      edge_cnt <= edge_cnt + 4'h1;
      sclk_q   <= ~sclk_q;
    end
  end

  // A slave with nothing new sends what is left in its transmit shifter.
  always_comb begin
    load_val = tx_empty ? tx_sh : tx_data;
    next_tx  = low_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
  end

  // Transmit shifter; the out bit is a flop so the pad sees no glitch.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_sh   <= 8'h00;
      out_bit <= 1'b0;
    end else if (start_now) begin
      tx_sh   <= load_val;
      out_bit <= low_first ? load_val[0] : load_val[7];
    end else if (drive_now) begin
      tx_sh   <= next_tx;
      out_bit <= low_first ? next_tx[0] : next_tx[7];
    end
  end

  // Receive shifter fills from the same end the far side sends first.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_sh <= 8'h00;
    end else if (sample_now) begin
      rx_sh <= low_first ? {serial_in, rx_sh[7:1]}
                         : {rx_sh[6:0], serial_in};
    end
  end

  // Status flags: a hardware set always beats a software clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_full    <= 1'b0;
      match_flag <= 1'b0;
      tx_empty   <= 1'b1;
      fault_flag <= 1'b0;
      rx_data    <= spms_pkg::DATA_RESET;
    end else begin
      if (copy_now) begin
        rx_full <= 1'b1;
        rx_data <= rx_sh;
      end else if (rx_clear) begin
        rx_full <= 1'b0;
      end
      if (copy_now & (rx_sh == match_value)) begin
        match_flag <= 1'b1;
      end else if (wr_status & wdata[spms_pkg::ST_MATCH]) begin
        match_flag <= 1'b0;
      end
      if (consume) begin
        tx_empty <= 1'b1;
      end else if (wr_data & tx_armed) begin
        tx_empty <= 1'b0;
      end
      if (fault_event) begin
        fault_flag <= 1'b1;
      end else if (wr_c1 & fault_armed) begin
        fault_flag <= 1'b0;
      end
    end
  end

  // Clear sequences: a status read with the flag set arms its clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_armed    <= 1'b0;
      tx_armed    <= 1'b0;
      fault_armed <= 1'b0;
    end else begin
      if (rd_status & rx_full) begin
        rx_armed <= 1'b1;
      end else if (rd_data) begin
        rx_armed <= 1'b0;
      end
      if (rd_status & tx_empty) begin
        tx_armed <= 1'b1;
      end else if (wr_data) begin
        tx_armed <= 1'b0;
      end
      if (rd_status & fault_flag) begin
        fault_armed <= 1'b1;
      end else if (wr_c1) begin
        fault_armed <= 1'b0;
      end
    end
  end

  // Interrupt and DMA requests; nothing is requested while disabled.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq        <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
    end else begin
      irq <= enabled &
             (((rx_full | fault_flag) & ctrl_one[spms_pkg::C1_RX_FAULT_IE]) |
              (tx_empty & ctrl_one[spms_pkg::C1_TX_IE]) |
              (match_flag & ctrl_two[spms_pkg::C2_MATCH_IE]));
      tx_dma_req <= enabled & tx_empty & ctrl_two[spms_pkg::C2_TX_DMA];
      rx_dma_req <= enabled & rx_full & ctrl_two[spms_pkg::C2_RX_DMA];
    end
  end

  // Pad drive. After a fault the port is a slave with its outputs off,
  // so it cannot fight the master that pulled the select line.
  logic m_drive;
  logic s_drive;
  assign m_drive = enabled & is_master & ~fault_flag;
  assign s_drive = enabled & ~is_master & ~fault_flag & ~pin_sync.ss_n_i;
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pins_out <= '0;
    end else begin
      pins_out.sclk_o  <= sclk_q;
      pins_out.sclk_oe <= m_drive;
      pins_out.mosi_o  <= out_bit;
      pins_out.mosi_oe <= m_drive & (~single_pin | shared_oe);
      pins_out.miso_o  <= out_bit;
      pins_out.miso_oe <= s_drive & (~single_pin | shared_oe);
      pins_out.ss_n_o  <= (state == spms_pkg::SPMS_IDLE); // Outlasts last edge.
      pins_out.ss_n_oe <= m_drive & fault_en & select_oe;
    end
  end

endmodule : spms_port

//--- tb/spms_port_sva.sv
/*
  Checker of the serial port: bus handshake timing, read data, reset
  state and master pin relations. Assumes it is bound to spms_port.
*/
`timescale 1ns/1ps
module spms_port_sva (
  input wire logic                       sys_clk,
  input wire logic                       rst,
  input wire logic [4:0]                 avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [31:0]                avs_writedata,
  input wire logic [31:0]                avs_readdata,
  input wire logic                       avs_waitrequest,
  input wire logic                       cpu_wait,
  input wire spms_pkg::spms_pin_in_type  pins_in,
  input wire spms_pkg::spms_pin_out_type pins_out,
  input wire logic                       irq,
  input wire logic                       tx_dma_req,
  input wire logic                       rx_dma_req
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // A held request is answered by exactly one low cycle of waitrequest.
  sequence s_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_ans;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  a_req_answered: assert property (s_req |=> s_ans)
    else $error("request not answered in one cycle");
  a_idle_quiet: assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("answer without request");
  a_read_upper: assert property (!avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_read_stands: assert property ($changed(avs_readdata) |-> !avs_waitrequest)
    else $error("read data moved outside an answer");
  a_reset_quiet: assert property ($fell(rst) |-> pins_out == '0 && !irq && !tx_dma_req && !rx_dma_req)
    else $error("outputs active after reset");
  a_clock_selected: assert property (pins_out.ss_n_oe && pins_out.ss_n_o && $past(pins_out.ss_n_oe) && $past(pins_out.ss_n_o) |-> $stable(pins_out.sclk_o))
    else $error("serial clock moved while not selected");
  a_select_master: assert property (!pins_out.sclk_oe |-> !pins_out.ss_n_oe)
    else $error("select driven outside master role");
  a_master_miso: assert property (pins_out.sclk_oe |-> !pins_out.miso_oe)
    else $error("master drives its input line");
endmodule : spms_port_sva

bind spms_port spms_port_sva u_sva (.sys_clk(sys_clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .cpu_wait(cpu_wait),
  .pins_in(pins_in), .pins_out(pins_out), .irq(irq),
  .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req));

//--- tb/spms_slave_model.sv
/*
  Behavioural serial slave on the far side of the port. Assumes a select
  line with a pull-up and a clock phase chosen by the bench.
*/
`timescale 1ns/1ps
module spms_slave_model (
  input  wire logic       sclk,
  input  wire logic       mosi,
  input  wire logic       ss_n,
  input  wire logic       phase,
  input  wire logic [7:0] reply,
  output      logic       miso,
  output      logic [7:0] got
);
  logic [4:0] cnt;
  logic [7:0] tx;
  logic [7:0] rx;
  initial begin
    cnt = 5'h00;
    tx = 8'h00;
    rx = 8'h00;
    got = 8'h00;
    miso = 1'b0;
  end
  // Select loads the reply; release inverts the line so stale data fails.
  always @(ss_n) begin
    cnt = 5'h00;
    tx = reply;
    miso = ss_n ? ~miso : reply[7];
  end
  // Even edges lead and odd ones trail; phase picks the sampling edge.
  always @(sclk) begin
    if (!ss_n && cnt < 5'h10) begin
      if (cnt[0] == phase) rx = {rx[6:0], mosi};
      else begin
        if (!phase) tx = tx << 1;
        miso = tx[7];
        if (phase) tx = tx << 1;
      end
      cnt = cnt + 5'h01;
      if (cnt == 5'h10) got = rx;
    end
  end
endmodule : spms_slave_model

//--- tb/tb_spms_port.sv
/*
  Testbench of the serial port: Avalon-MM register tests and transfers
  against the slave model. Assumes the design package and checker.
*/
`timescale 1ns/1ps
module tb_spms_port;
  logic                       sys_clk = 1'b0;
  logic                       rst = 1'b1;
  logic [4:0]                 avs_address = 5'h00;
  logic                       avs_read = 1'b0;
  logic                       avs_write = 1'b0;
  logic [31:0]                avs_writedata = 32'h0;
  logic [31:0]                avs_readdata;
  logic                       avs_waitrequest, irq, tx_dma_req, rx_dma_req;
  spms_pkg::spms_pin_in_type  pins_in;
  spms_pkg::spms_pin_out_type pins_out;
  logic                       ss_force = 1'b0, phase = 1'b0, ss_n, miso, last;
  logic                       cpu_wait = 1'b0;
  logic [7:0]                 reply = 8'h00, got, q;
  int                         fails = 0, cmp_count = 0, edges, gap, run, cyc;
  logic [4:0]                 ra [6] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14};
  logic [7:0]                 rv [6] = '{spms_pkg::CTRL_ONE_RESET,
    spms_pkg::CTRL_TWO_RESET, spms_pkg::RATE_RESET, 8'h20,
    spms_pkg::MATCH_RESET, spms_pkg::DATA_RESET};
  logic [4:0]                 wa [5] = '{5'h04, 5'h08, 5'h10, 5'h0C, 5'h18};
  logic [7:0]                 wd [5] = '{8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'hFF};
  logic [7:0]                 we [5] = '{spms_pkg::C2_WRITE_MASK,
    spms_pkg::RATE_WRITE_MASK, 8'hA5, 8'h20, 8'h00};

  // The select line has a pull-up; the bench can pull it low for a fault.
  assign ss_n = pins_out.ss_n_oe ? pins_out.ss_n_o : 1'b1;
  assign pins_in = {pins_out.sclk_o, pins_out.mosi_o, miso, ss_n & ~ss_force};

  spms_port dut (.sys_clk(sys_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_wait(cpu_wait), .pins_in(pins_in),
    .pins_out(pins_out), .irq(irq), .tx_dma_req(tx_dma_req),
    .rx_dma_req(rx_dma_req));
  spms_slave_model slave (.sclk(pins_out.sclk_o), .mosi(pins_out.mosi_o),
    .ss_n(pins_in.ss_n_i), .phase(phase), .reply(reply), .miso(miso),
    .got(got));

  always #5 sys_clk = ~sys_clk;

  // Counts serial clock edges, the shortest half period, and a hang limit.
  always @(posedge sys_clk) begin
    cyc++;
    run++;
    if (pins_out.sclk_o !== last) begin
      edges++;
      if (run < gap) gap = run;
      run = 0;
    end
    last = pins_out.sclk_o;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end

  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // One bus cycle, held until waitrequest is sampled low; then a free edge.
  task automatic bus(input logic [4:0] a, input logic w, input logic [7:0] d);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask : bus

  task automatic rdc(input logic [4:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(q, e);
  endtask : rdc

  task automatic poll(input int b);
    do bus(5'h0C, 1'b0, 8'h00); while (q[b] !== 1'b1);
  endtask : poll

  // Software order: rate, control, status check, then the data write.
  task automatic xfer(input logic [7:0] c1, r, tx, rp);
    reply <= rp;
    bus(5'h08, 1'b1, r);
    bus(5'h00, 1'b1, c1);
    edges = 0;
    gap = 99;
    rdc(5'h0C, 8'h20);
    bus(5'h14, 1'b1, tx);
    poll(spms_pkg::ST_RX_FULL);
    chk(edges[7:0], 8'h10);
  endtask : xfer

  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int i = 0; i < 6; i++) rdc(ra[i], rv[i]);
    for (int i = 0; i < 5; i++) begin
      bus(wa[i], 1'b1, wd[i]);
      rdc(wa[i], we[i]);
    end
    // Slow master, phase one, high bit first, match and transmit DMA on.
    phase <= 1'b1;
    bus(5'h04, 1'b1, 8'hB0);
    bus(5'h10, 1'b1, 8'hC3);
    xfer(8'h56, 8'h02, 8'h3C, 8'hC3);
    chk(gap[7:0], 8'h04);
    chk(got, 8'h3C);
    chk({irq, tx_dma_req, 6'h0}, 8'hC0);
    rdc(5'h0C, 8'hE0);
    rdc(5'h14, 8'hC3);
    bus(5'h0C, 1'b1, 8'h40);
    rdc(5'h0C, 8'h20);
    chk({irq, tx_dma_req, 6'h0}, 8'h40);
    // Fastest rate, phase zero, inverted clock, low bit first.
    phase <= 1'b0;
    // Move the idle clock level with the port off; it is no serial edge.
    bus(5'h00, 1'b1, 8'h08);
    bus(5'h04, 1'b1, 8'h14);
    xfer(8'h5B, 8'h00, 8'h12, 8'h00);
    chk(gap[7:0], 8'h01);
    chk(got, 8'h48);
    chk({rx_dma_req, 7'h0}, 8'h80);
    bus(5'h14, 1'b0, 8'h00);
    // Stop in wait: the master clock holds while the processor waits.
    bus(5'h04, 1'b1, 8'h16);
    cpu_wait <= 1'b1;
    rdc(5'h0C, 8'h20);
    bus(5'h14, 1'b1, 8'h5A);
    edges = 0;
    repeat (40) @(posedge sys_clk);
    chk(edges[7:0], 8'h00);
    cpu_wait <= 1'b0;
    poll(spms_pkg::ST_RX_FULL);
    chk(edges[7:0], 8'h10);
    chk(got, 8'h5A);
    bus(5'h14, 1'b0, 8'h00);
    // Select pulled low on a master without select output.
    bus(5'h00, 1'b1, 8'hD0);
    ss_force <= 1'b1;
    poll(spms_pkg::ST_FAULT);
    rdc(5'h00, 8'hC0);
    chk({irq, 7'h0}, 8'h80);
    ss_force <= 1'b0;
    bus(5'h00, 1'b1, 8'h00);
    rdc(5'h0C, 8'h20);
    chk({irq, 7'h0}, 8'h00);
    final_report;
  end
endmodule : tb_spms_port
